/* File: bench/gpio_port_with_analog_share_test.sv */
// Purpose: self-checking bench for the shared-function port
// Assumes: default pin parameters, register index map of the package
// Notes:   pin reads waited out over the input synchroniser
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module gpio_port_with_analog_share_test;
  logic       clk = 1'b0, reset_n = 1'b0, wrStb = 1'b0, rdStb = 1'b0, rdRmw = 1'b0;
  logic       stopWatch = 1'b0, sel, fl;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00, periphOe = 8'h00, periphOut = 8'h00, wakeIrqEn = 8'h00;
  logic [7:0] extVal = 8'h00, extEn = 8'hFF, rdData, pinOut, pinOe_n, pullUpOn, digIn, pinIn;
  logic [7:0] lat, dir, pul, ana, drv, val, lvl;
  int         failures = 0, checks = 0;

  always #5 clk = ~clk;

  gpp_port gpp_port_i (.clk(clk), .reset_n(reset_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdRmw(rdRmw), .rdData(rdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe_n(pinOe_n), .pullUpOn(pullUpOn), .digIn(digIn),
    .periphOe(periphOe), .periphOut(periphOut), .stopWatch(stopWatch),
    .wakeIrqEn(wakeIrqEn));
  gpp_pin_model gpp_pin_model_i (.clk(clk), .pinOut(pinOut), .pinOe_n(pinOe_n),
    .pullUpOn(pullUpOn), .extVal(extVal), .extEn(extEn), .pinIn(pinIn));

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
  endtask : wr

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rdRmw <= m;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 `CHK(rdData, e)
  endtask : rd

  task automatic end_sim;
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////
  // random configurations against the integer model
  initial
  begin
    void'($urandom(51));
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 1'b0, 8'h00);
    // directed: peripherals off, every pin an output, then analog use
    periphOe <= 8'h00;
    wr(gpp_pkg::GPP_IDX_DIR, 8'hFF);
    wr(gpp_pkg::GPP_IDX_LATCH, 8'h5A);
    repeat (3) @(posedge clk);
    #1 `CHK(pinOut, 8'h5A)
    `CHK(pinOe_n, 8'h00)
    wr(gpp_pkg::GPP_IDX_DIR, 8'h00);
    wr(gpp_pkg::GPP_IDX_ANADIS, 8'h00);
    wr(gpp_pkg::GPP_IDX_PULL, 8'h00);
    extVal <= 8'hFF;
    repeat (10) @(posedge clk);
    #1 `CHK(digIn, 8'hFF & ~gpp_pkg::GPP_ANA_PINS)
    `CHK(pullUpOn, 8'h00)
    rd(gpp_pkg::GPP_IDX_LATCH, 1'b1, 8'h5A);
    for (int i = 0; i < 40; i++)
    begin
      lat = 8'($urandom);
      dir = 8'($urandom);
      pul = 8'($urandom);
      ana = 8'($urandom);
      sel = 1'($urandom);
      wr(gpp_pkg::GPP_IDX_LATCH, lat);
      wr(gpp_pkg::GPP_IDX_DIR, dir);
      wr(gpp_pkg::GPP_IDX_PULL, pul);
      wr(gpp_pkg::GPP_IDX_ANADIS, ana);
      wr(gpp_pkg::GPP_IDX_STBY, {7'h00, sel});
      periphOe <= 8'($urandom);
      periphOut <= 8'($urandom);
      wakeIrqEn <= 8'($urandom);
      extVal <= 8'($urandom);
      stopWatch <= 1'($urandom);
      @(posedge clk);
      fl = stopWatch & sel;
      drv = fl ? 8'h00 : (dir | periphOe);
      val = (periphOe & periphOut) | (~periphOe & lat);
      lvl = (drv & val) | (~drv & extVal);
      // outside driver only on pins the port leaves alone
      extEn <= ~drv;
      repeat (10) @(posedge clk);
      `CHK(pinOe_n, ~drv)
      `CHK(pinOut & drv, val & drv)
      `CHK(pullUpOn, pul & ~(drv & ~val))
      `CHK(digIn, fl ? (lvl & gpp_pkg::GPP_WAKE_PINS & wakeIrqEn) : (lvl & ~(gpp_pkg::GPP_ANA_PINS & ~ana)))
      if (!fl) rd(gpp_pkg::GPP_IDX_LATCH, 1'b0, (dir & ~periphOe & lat) | (~(dir & ~periphOe) & lvl));
      rd(gpp_pkg::GPP_IDX_LATCH, 1'b1, lat);
      rd(gpp_pkg::GPP_IDX_DIR, 1'b0, dir);
      rd(gpp_pkg::GPP_IDX_ANADIS, 1'b0, ana & gpp_pkg::GPP_ANA_PINS);
      rd(gpp_pkg::GPP_IDX_WAKEEN, 1'b0, wakeIrqEn & gpp_pkg::GPP_WAKE_PINS);
      rd(gpp_pkg::GPP_IDX_STBY, 1'b0, {7'h00, sel});
    end
    // second reset in mid-run
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(pinOe_n, 8'hFF)
    reset_n <= 1'b1;
    rd(gpp_pkg::GPP_IDX_DIR, 1'b0, 8'h00);
    rd(gpp_pkg::GPP_IDX_PULL, 1'b0, 8'h00);
    rd(gpp_pkg::GPP_IDX_ANADIS, 1'b0, 8'h00);
    end_sim();
  end

  // the run needs about 1400 cycles
  initial
  begin
    #100000;
    failures++;
    end_sim();
  end
endmodule : gpio_port_with_analog_share_test

/* File: bench/gpp_pin_model.sv */
// Purpose: far-side pin model, external driver plus pull-up
// Assumes: outside driver only where the port does not drive
// Notes:   open pins toggle every cycle so nothing relies on them
`timescale 1ns/1ns
module gpp_pin_model (
  input  wire logic       clk,
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOe_n,
  input  wire logic [7:0] pullUpOn,
  input  wire logic [7:0] extVal,
  input  wire logic [7:0] extEn,
  output logic      [7:0] pinIn
);
  logic [7:0] flt = 8'h00;
  // wandering level stands in for an open pin
  always @(posedge clk) flt <= ~flt;
  // port drive wins, then the outside driver, then pull-up or wander
  always_comb pinIn = (~pinOe_n & pinOut) | (pinOe_n & extEn & extVal)
                    | (pinOe_n & ~extEn & (pullUpOn | flt));
endmodule : gpp_pin_model

/* File: hdl/gpp_pkg.sv */
// Purpose: constants for the shared-function 8-bit port
// Assumes: plain register port, 8-bit data, word index addressing
// Notes:   register indices are local choices
// Summary of operation
// - direction bit one makes the pin a general-purpose output
// - output pin drives its latch bit
// - latch write appears at once on output pins; here one clock after the latch takes it, as the pad outputs are registered
// - read of an output pin returns the latch bit
// - direction bit zero makes the pin an input, drive off
// - latch write on an input pin is stored but not driven
// - input pin read gives pin level, read-modify-write gives latch
// - enabled peripheral output overrides the port output path
// - peripheral-driven pin reads its level, read-modify-write gives latch
// - pin level is read whether or not a peripheral uses it as input
// - reset clears direction, all pins inputs
// - reset clears analog disable, digital input off on analog pins
// - standby select one in stop or watch: pins float, input held low
// - wake-capable pins with interrupt enabled keep their input
// - standby select zero: pin states and output levels kept
// - pull-up enable one connects the pull-up
// - pull-up disconnected while the pin drives low
package gpp_pkg;
  localparam int          GPP_WIDTH      = 8;
  localparam int          GPP_ADDR_W     = 3;
  localparam logic [2:0]  GPP_IDX_LATCH  = 3'h0;
  localparam logic [2:0]  GPP_IDX_DIR    = 3'h1;
  localparam logic [2:0]  GPP_IDX_PULL   = 3'h2;
  localparam logic [2:0]  GPP_IDX_ANADIS = 3'h3;
  localparam logic [2:0]  GPP_IDX_STBY   = 3'h4;
  localparam logic [2:0]  GPP_IDX_WAKEEN = 3'h5;
  localparam logic [7:0]  GPP_RST_BYTE   = 8'h00;
  localparam int          GPP_STBY_SEL_BIT = 0;
  localparam logic [7:0]  GPP_ANA_PINS   = 8'h0F;
  localparam logic [7:0]  GPP_WAKE_PINS  = 8'hA0;
endpackage : gpp_pkg

/* File: hdl/gpp_port.sv */
// Purpose: 8-bit port with peripheral sharing, analog share, standby float
// Assumes: pins arrive asynchronously, three-stage synchronised
// Notes:   pin output enables are active low
`timescale 1ns/1ns
module gpp_port #(
  parameter logic [7:0] ANA_PINS  = gpp_pkg::GPP_ANA_PINS,
  parameter logic [7:0] WAKE_PINS = gpp_pkg::GPP_WAKE_PINS
) (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  input  wire logic       rdRmw,
  output logic      [7:0] rdData,
  input  wire logic [7:0] pinIn,
  output logic      [7:0] pinOut,
  output logic      [7:0] pinOe_n,
  output logic      [7:0] pullUpOn,
  output logic      [7:0] digIn,
  input  wire logic [7:0] periphOe,
  input  wire logic [7:0] periphOut,
  input  wire logic       stopWatch,
  input  wire logic [7:0] wakeIrqEn
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0] port6_output_latch;
  logic [7:0] port6_direction;
  logic [7:0] port6_pullup_enable;
  logic [7:0] analog_input_disable_upper;
  logic [7:0] standby_control;
  logic [7:0] sync1;
  logic [7:0] sync2;
  logic [7:0] sync3;
  logic [7:0] pinLevel;
  logic       floatAll;
  logic [7:0] next_pinOut;
  logic [7:0] next_oe_n;
  logic [7:0] next_pull;
  logic [7:0] next_digIn;
  logic [7:0] next_rdData;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] idx);
    return a == idx;
  endfunction : hit

  // software writes, all cleared on reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      port6_output_latch         <= gpp_pkg::GPP_RST_BYTE;
      port6_direction            <= gpp_pkg::GPP_RST_BYTE;
      port6_pullup_enable        <= gpp_pkg::GPP_RST_BYTE;
      analog_input_disable_upper <= gpp_pkg::GPP_RST_BYTE;
      standby_control            <= gpp_pkg::GPP_RST_BYTE;
    end
    else if (wrStb)
    begin
      if (hit(addr, gpp_pkg::GPP_IDX_LATCH))
        port6_output_latch <= wrData;
      if (hit(addr, gpp_pkg::GPP_IDX_DIR))
        port6_direction <= wrData;
      if (hit(addr, gpp_pkg::GPP_IDX_PULL))
        port6_pullup_enable <= wrData;
      if (hit(addr, gpp_pkg::GPP_IDX_ANADIS))
        analog_input_disable_upper <= wrData & ANA_PINS;
      if (hit(addr, gpp_pkg::GPP_IDX_STBY))
        standby_control <= wrData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser: a change counts once stages two and three agree
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1    <= gpp_pkg::GPP_RST_BYTE;
      sync2    <= gpp_pkg::GPP_RST_BYTE;
      sync3    <= gpp_pkg::GPP_RST_BYTE;
      pinLevel <= gpp_pkg::GPP_RST_BYTE;
    end
    else
    begin
      sync1    <= pinIn;
      sync2    <= sync1;
      sync3    <= sync2;
      pinLevel <= (sync2 & sync3) | (pinLevel & (sync2 | sync3));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drive: peripheral over port, standby float over both
  always_comb
  begin
    floatAll = stopWatch && standby_control[gpp_pkg::GPP_STBY_SEL_BIT];
    for (int i = 0; i < gpp_pkg::GPP_WIDTH; i++)
    begin
      if (periphOe[i])
      begin
        next_pinOut[i] = periphOut[i];
        next_oe_n[i]   = 1'b0;
      end
      else if (port6_direction[i])
      begin
        next_pinOut[i] = port6_output_latch[i];
        next_oe_n[i]   = 1'b0;
      end
      else
      begin
        next_pinOut[i] = 1'b0;
        next_oe_n[i]   = 1'b1;
      end
      if (floatAll)
        next_oe_n[i] = 1'b1;
      // pull-up off when driving low, saves the resistor current
      next_pull[i] = port6_pullup_enable[i] && !(!next_oe_n[i] && !next_pinOut[i]);
      // analog-shared pins need the disable bit before digital input works
      next_digIn[i] = pinLevel[i] && (!ANA_PINS[i] || analog_input_disable_upper[i]);
      if (floatAll && !(WAKE_PINS[i] && wakeIrqEn[i]))
        next_digIn[i] = 1'b0;
    end
  end

  // register the pad controls so every output is a flop
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pinOut   <= gpp_pkg::GPP_RST_BYTE;
      pinOe_n  <= ~gpp_pkg::GPP_RST_BYTE;
      pullUpOn <= gpp_pkg::GPP_RST_BYTE;
      digIn    <= gpp_pkg::GPP_RST_BYTE;
    end
    else
    begin
      pinOut   <= next_pinOut;
      pinOe_n  <= next_oe_n;
      pullUpOn <= next_pull;
      digIn    <= next_digIn;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux: data reads pick latch or pin per bit
  always_comb
  begin
    next_rdData = gpp_pkg::GPP_RST_BYTE;
    unique case (addr)
      gpp_pkg::GPP_IDX_LATCH:
        for (int i = 0; i < gpp_pkg::GPP_WIDTH; i++)
          next_rdData[i] = (rdRmw || (port6_direction[i] && !periphOe[i]))
                         ? port6_output_latch[i] : pinLevel[i];
      gpp_pkg::GPP_IDX_DIR:    next_rdData = port6_direction;
      gpp_pkg::GPP_IDX_PULL:   next_rdData = port6_pullup_enable;
      gpp_pkg::GPP_IDX_ANADIS: next_rdData = analog_input_disable_upper;
      gpp_pkg::GPP_IDX_STBY:   next_rdData = standby_control;
      gpp_pkg::GPP_IDX_WAKEEN: next_rdData = wakeIrqEn & WAKE_PINS;
      default:                 next_rdData = gpp_pkg::GPP_RST_BYTE;
    endcase
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData <= gpp_pkg::GPP_RST_BYTE;
    else if (rdStb)
      rdData <= next_rdData;
    else
      rdData <= gpp_pkg::GPP_RST_BYTE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // multi-step behaviours are built from these named steps
  sequence latchWrite_s;
    wrStb && addr == gpp_pkg::GPP_IDX_LATCH;
  endsequence

  sequence dirWrite_s;
    wrStb && addr == gpp_pkg::GPP_IDX_DIR;
  endsequence

  sequence pullWrite_s;
    wrStb && addr == gpp_pkg::GPP_IDX_PULL;
  endsequence

  sequence anaWrite_s;
    wrStb && addr == gpp_pkg::GPP_IDX_ANADIS;
  endsequence

  sequence allOut_s;
    port6_direction == 8'hFF && periphOe == 8'h00 && !floatAll;
  endsequence

  sequence plainRead_s;
    rdStb && !rdRmw && addr == gpp_pkg::GPP_IDX_LATCH;
  endsequence

  // properties below, one per guarded behaviour
  // a fresh latch value reaches every output pin one edge later
  outDrive_a: assert property (@(posedge clk) disable iff (!reset_n)
    latchWrite_s ##1 allOut_s
    |=> pinOut == $past(port6_output_latch) && pinOe_n == 8'h00)
    else $error("output pin not driving latch");

  // all inputs and no peripheral: nothing driven
  inputOff_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port6_direction == 8'h00 && periphOe == 8'h00) |=> pinOe_n == 8'hFF)
    else $error("input pin is driven");

  // peripheral drive on bit zero
  periphWins_a: assert property (@(posedge clk) disable iff (!reset_n)
    (periphOe[0] && !floatAll) |=> (pinOut[0] == $past(periphOut[0]) && !pinOe_n[0]))
    else $error("peripheral output not on pin");

  // read-modify-write always sees the whole latch
  rmwRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && rdRmw && addr == gpp_pkg::GPP_IDX_LATCH) |=> rdData == $past(port6_output_latch))
    else $error("rmw read not latch");

  // plain read with every pin an input gives the pin levels
  pinRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && !rdRmw && addr == gpp_pkg::GPP_IDX_LATCH && port6_direction == 8'h00)
    |=> rdData == $past(pinLevel))
    else $error("pin read not pin level");

  // forced float: no drive, inputs low except enabled wake pins
  stbyFloat_a: assert property (@(posedge clk) disable iff (!reset_n)
    floatAll |=> pinOe_n == 8'hFF && (digIn & ~(WAKE_PINS & $past(wakeIrqEn))) == 8'h00)
    else $error("standby float missing");

  // same cycle: drive, level and pull-up leave one flop stage together
  pullLow_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!pinOe_n[0] && !pinOut[0]) |-> !pullUpOn[0])
    else $error("pull-up on while driving low");

  // analog-shared pins stay blocked until software opens them
  anaBlock_a: assert property (@(posedge clk) disable iff (!reset_n)
    (analog_input_disable_upper == 8'h00) |=> (digIn & ANA_PINS) == 8'h00)
    else $error("analog pin digital input open");

  // latch write lands whole
  latchStore_a: assert property (@(posedge clk) disable iff (!reset_n)
    latchWrite_s |=> port6_output_latch == $past(wrData))
    else $error("latch write lost");

  // direction write lands whole
  dirStore_a: assert property (@(posedge clk) disable iff (!reset_n)
    dirWrite_s |=> port6_direction == $past(wrData))
    else $error("direction write lost");

  // pull-up enable write lands whole
  pullStore_a: assert property (@(posedge clk) disable iff (!reset_n)
    pullWrite_s |=> port6_pullup_enable == $past(wrData))
    else $error("pull-up write lost");

  // analog disable keeps only bits of analog-shared pins
  anaStore_a: assert property (@(posedge clk) disable iff (!reset_n)
    anaWrite_s |=> analog_input_disable_upper == ($past(wrData) & ANA_PINS))
    else $error("analog disable write wrong");

  // a plain output pin carries its latch bit and is driven
  outBit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port6_direction[1] && !periphOe[1] && !floatAll)
    |=> pinOut[1] == $past(port6_output_latch[1]) && !pinOe_n[1])
    else $error("output bit not latch");

  // an input bit is never driven by the port
  inBit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!port6_direction[2] && !periphOe[2]) |=> pinOe_n[2])
    else $error("input bit driven");

  // a latch write to an input bit stays off the pin
  inLatch_a: assert property (@(posedge clk) disable iff (!reset_n)
    latchWrite_s ##0 (!port6_direction[3] && !periphOe[3]) |=> pinOe_n[3])
    else $error("input bit driven after write");

  // peripheral drive takes bit three away from the port latch
  periphBit_a: assert property (@(posedge clk) disable iff (!reset_n)
    (periphOe[3] && !floatAll)
    |=> pinOut[3] == $past(periphOut[3]) && !pinOe_n[3])
    else $error("peripheral bit not on pin");

  // plain read of an output bit returns the latch
  outRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    plainRead_s ##0 (port6_direction[0] && !periphOe[0])
    |=> rdData[0] == $past(port6_output_latch[0]))
    else $error("output read not latch");

  // plain read of a peripheral-driven bit returns the pin
  periphRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    plainRead_s ##0 periphOe[1] |=> rdData[1] == $past(pinLevel[1]))
    else $error("peripheral read not pin level");

  // plain read of an input bit returns the pin
  inRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    plainRead_s ##0 !port6_direction[2] |=> rdData[2] == $past(pinLevel[2]))
    else $error("input read not pin level");

  // read-modify-write of a peripheral pin still sees the latch
  periphRmw_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && rdRmw && addr == gpp_pkg::GPP_IDX_LATCH && periphOe[4])
    |=> rdData[4] == $past(port6_output_latch[4]))
    else $error("peripheral rmw read not latch");

  // read data stands only after a strobe, zero otherwise
  rdIdle_a: assert property (@(posedge clk) disable iff (!reset_n)
    !rdStb |=> rdData == 8'h00)
    else $error("read data without strobe");

  // direction reads back as written
  dirRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && addr == gpp_pkg::GPP_IDX_DIR) |=> rdData == $past(port6_direction))
    else $error("direction read wrong");

  // analog disable reads back as stored
  anaRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && addr == gpp_pkg::GPP_IDX_ANADIS) |=> rdData == $past(analog_input_disable_upper))
    else $error("analog disable read wrong");

  // pull-up enable reads back as written
  pullRead_a: assert property (@(posedge clk) disable iff (!reset_n)
    (rdStb && addr == gpp_pkg::GPP_IDX_PULL) |=> rdData == $past(port6_pullup_enable))
    else $error("pull-up read wrong");

  // an enabled wake pin keeps its input through forced float
  wakeKeep_a: assert property (@(posedge clk) disable iff (!reset_n)
    (floatAll && WAKE_PINS[5] && wakeIrqEn[5] && !ANA_PINS[5])
    |=> digIn[5] == $past(pinLevel[5]))
    else $error("wake pin input blocked");

  // a pin that cannot wake is held low during forced float
  floatBlock_a: assert property (@(posedge clk) disable iff (!reset_n)
    (floatAll && !WAKE_PINS[0]) |=> !digIn[0])
    else $error("float input not blocked");

  // without forced float the port keeps its drive choice
  holdState_a: assert property (@(posedge clk) disable iff (!reset_n)
    (!floatAll && !periphOe[4]) |=> pinOe_n[4] == !$past(port6_direction[4]))
    else $error("pin state not kept");

  // enabled pull-up on an undriven pin is connected
  pullOn_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port6_pullup_enable[1] && next_oe_n[1]) |=> pullUpOn[1])
    else $error("pull-up not connected");

  // disabled pull-up is never connected
  pullOff_a: assert property (@(posedge clk) disable iff (!reset_n)
    !port6_pullup_enable[2] |=> !pullUpOn[2])
    else $error("pull-up connected while off");

  // driving low drops the pull-up even with the enable set
  pullDrop_a: assert property (@(posedge clk) disable iff (!reset_n)
    (port6_pullup_enable[3] && !next_oe_n[3] && !next_pinOut[3])
    |=> !pullUpOn[3])
    else $error("pull-up kept while driving low");

  // opened analog pin passes its level to the peripherals
  anaOpen_a: assert property (@(posedge clk) disable iff (!reset_n)
    (analog_input_disable_upper[0] && !floatAll) |=> digIn[0] == $past(pinLevel[0]))
    else $error("opened analog pin blocked");

  // disagreeing late stages must not move the settled level
  syncHold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (sync2[0] != sync3[0]) |=> pinLevel[0] == $past(pinLevel[0]))
    else $error("pin level moved before agreement");

endmodule : gpp_port
